// ### pkg/stc_pkg.sv
// Purpose: Shared constants and types for the sixteen-bit timer/counter three block.
// Assumes: AHB-Lite register access with 32-bit data, one register per aligned word.
// Notes:   Register fields sit in the low byte, except the 16-bit compare value; upper bits read as zero.
package stc_pkg;

  // ===========================================================================
  // Register map
  localparam logic [7:0] STC_OFS_CTRL = 8'h00;
  localparam logic [7:0] STC_OFS_CNTL = 8'h04;
  localparam logic [7:0] STC_OFS_CNTH = 8'h08;
  localparam logic [7:0] STC_OFS_FLAG = 8'h0c;
  localparam logic [7:0] STC_OFS_IEN  = 8'h10;
  localparam logic [7:0] STC_OFS_PRIO = 8'h14;
  localparam logic [7:0] STC_OFS_AUX  = 8'h18;
  localparam logic [7:0] STC_OFS_CMP  = 8'h1c;
  localparam logic [7:0] STC_OFS_PORT = 8'h20;

  // ===========================================================================
  // Field positions and reset values
  localparam int         STC_OVF_BIT     = 1;
  localparam int         STC_OSC_EN_BIT  = 0;
  localparam logic [7:0] STC_CTRL_RST    = 8'h00;
  localparam logic [7:0] STC_FLAG_RST    = 8'h00;
  localparam logic [7:0] STC_IEN_RST     = 8'h00;
  localparam logic [7:0] STC_PRIO_RST    = 8'h1f;
  localparam logic [1:0] STC_DIR_RST     = 2'h3;
  localparam logic [3:0] STC_MODE_TRIG   = 4'hb;
  localparam logic [15:0] STC_CNT_MAX    = 16'hffff;

  // ===========================================================================
  // Timing: the instruction clock is the system clock divided by four
  localparam logic [1:0] STC_INSTR_LAST  = 2'h3;

  typedef struct packed {
    logic       wide;
    logic       route_hi;
    logic [1:0] prescale;
    logic       route_lo;
    logic       sync_dis;
    logic       src;
    logic       on;
  } stc_ctrl_type;

  typedef enum logic {STC_WAIT_FALL, STC_ARMED} stc_arm_type;

endpackage

// ### src/stc_timer.sv
// Purpose: Sixteen-bit timer/counter three with prescaler, trigger clear and AHB-Lite access.
// Assumes: Single clock hclk at 50 MHz; pin inputs are synchronous to hclk.
// Notes:   Zero-wait-state slave; every response is OKAY.
// Overview of operation
// - Count up through every value, wrap ffff to 0000 and flag overflow.
// - Overflow latches its flag; interrupt forwarded only when enabled.
// - Wide-access bit selects one 16-bit access or two byte accesses.
// - Routing field assigns first or second timer pair to five compare units.
// - Prescale field divides the count source by 1, 2, 4 or 8.
// - External source synchronised when sync-disable is clear; ignored for internal.
// - External mode counts rising edges only after a first falling edge.
// - Internal mode counts once per instruction cycle, system clock over four.
// - On bit enables counting; clearing it holds the value, though a trigger still clears it.
// - Shared oscillator enabled forces both oscillator pins to input, reads zero.
// - Shared oscillator enable selects the oscillator as external count source.
// - Compare unit in trigger mode clears the counter on each trigger.
// - Trigger clear never sets the overflow flag.
// - Counter write in the trigger cycle wins over the clear.
// - Compare value acts as period, count runs zero up to match.
`timescale 1ns/1ps
module stc_timer
  import stc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  pin_in,
  output logic      [1:0]  pin_out,
  output logic      [1:0]  pin_oe_n,
  output logic      [4:0]  unit_second_pair,
  output logic             irq,
  output logic             irq_priority
);

  // ===========================================================================
  // Registers
  stc_ctrl_type ctrl_ff;
  logic [15:0]  cnt_ff;
  logic [7:0]   hbuf_ff;
  logic [7:0]   flag_ff;
  logic [7:0]   ien_ff;
  logic [7:0]   prio_ff;
  logic         osc_en_ff;
  logic [3:0]   cmp_mode_ff;
  logic [15:0]  cmp_ff;
  logic [1:0]   dir_ff;
  logic [1:0]   pout_ff;
  logic         wr_pend_ff;
  logic [7:0]   waddr_ff;
  logic [31:0]  hrdata_ff;
  logic [1:0]   div_ff;
  logic [2:0]   psc_ff;
  logic         s1_ff;
  logic         s2_ff;
  logic         s3_ff;
  logic         raw_prev_ff;
  stc_arm_type  arm_ff;

  logic        rd_take;
  logic        wr_take;
  logic [7:0]  wbyte;
  logic        wr_cntl;
  logic        wr_cnth;
  logic        cnt_wr;
  logic [15:0] cnt_wval;
  logic        ext_raw;
  logic        ext_cur;
  logic        ext_old;
  logic        ext_rise;
  logic        ext_fall;
  logic        div_tick;
  logic        src_tick;
  logic        inc;
  logic        trig;
  logic        ovf_evt;
  logic [1:0]  pin_rd;

  // The last prescaler count is one less than the division ratio.
  function automatic logic [2:0] psc_last(input logic [1:0] sel);
    psc_last = 3'(({1'b0, 2'h0} + 3'h1 << sel) - 3'h1);
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    unique case (ofs)
      STC_OFS_CTRL: reg_read = ctrl_ff;
      STC_OFS_CNTL: reg_read = cnt_ff[7:0];
      STC_OFS_CNTH: reg_read = ctrl_ff.wide ? hbuf_ff : cnt_ff[15:8];
      STC_OFS_FLAG: reg_read = flag_ff;
      STC_OFS_IEN:  reg_read = ien_ff;
      STC_OFS_PRIO: reg_read = prio_ff;
      STC_OFS_AUX:  reg_read = {cmp_mode_ff, 3'h0, osc_en_ff};
      STC_OFS_CMP:  reg_read = cmp_ff[7:0];
      STC_OFS_PORT: reg_read = {2'h0, pin_rd, pout_ff, dir_ff};
      default:      reg_read = 8'h00;
    endcase
  endfunction

  // ===========================================================================
  // AHB-Lite slave
  assign rd_take   = hsel & htrans[1] & hready & ~hwrite;
  assign wr_take   = hsel & htrans[1] & hready & hwrite;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign wbyte     = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= wr_take;
      if (wr_take) begin
        waddr_ff <= haddr[7:0];
      end
      if (rd_take) begin
        if (haddr[7:0] == STC_OFS_CMP) begin
          hrdata_ff <= {16'h0000, cmp_ff};
        end else begin
          hrdata_ff <= {24'h000000, reg_read(haddr[7:0])};
        end
      end
    end
  end

  // ===========================================================================
  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff     <= STC_CTRL_RST;
      ien_ff      <= STC_IEN_RST;
      prio_ff     <= STC_PRIO_RST;
      osc_en_ff   <= 1'b0;
      cmp_mode_ff <= 4'h0;
      cmp_ff      <= 16'h0000;
      dir_ff      <= STC_DIR_RST;
      pout_ff     <= 2'h0;
    end else if (wr_pend_ff) begin
      unique case (waddr_ff)
        STC_OFS_CTRL: ctrl_ff <= wbyte;
        STC_OFS_IEN:  ien_ff  <= wbyte;
        STC_OFS_PRIO: prio_ff <= wbyte;
        STC_OFS_AUX: begin
          osc_en_ff   <= wbyte[STC_OSC_EN_BIT];
          cmp_mode_ff <= wbyte[7:4];
        end
        STC_OFS_CMP:  cmp_ff <= hwdata[15:0];
        STC_OFS_PORT: begin
          dir_ff  <= wbyte[1:0];
          pout_ff <= wbyte[3:2];
        end
        default: ;
      endcase
    end
  end

  // ===========================================================================
  // Oscillator pins and compare routing
  // The oscillator pins are released whenever the shared oscillator runs.
  assign pin_oe_n = osc_en_ff ? 2'h3 : dir_ff;
  assign pin_out  = pout_ff;
  assign pin_rd   = osc_en_ff ? 2'h0 : pin_in;

  always_comb begin
    unique case ({ctrl_ff.route_hi, ctrl_ff.route_lo})
      2'b11:   unit_second_pair = 5'h1f;
      2'b10:   unit_second_pair = 5'h1c;
      2'b01:   unit_second_pair = 5'h1e;
      default: unit_second_pair = 5'h00;
    endcase
  end

  // ===========================================================================
  // Count source selection
  assign ext_raw = osc_en_ff ? pin_in[1] : pin_in[0];

  // The unsynchronised path trades trigger-clear safety for lower latency.
  assign ext_cur  = ctrl_ff.sync_dis ? ext_raw : s2_ff;
  assign ext_old  = ctrl_ff.sync_dis ? raw_prev_ff : s3_ff;
  assign ext_rise = ext_cur & ~ext_old;
  assign ext_fall = ~ext_cur & ext_old;
  assign div_tick = (div_ff == STC_INSTR_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff       <= 1'b0;
      s2_ff       <= 1'b0;
      s3_ff       <= 1'b0;
      raw_prev_ff <= 1'b0;
      div_ff      <= 2'h0;
    end else begin
      s1_ff       <= ext_raw;
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      raw_prev_ff <= ext_raw;
      div_ff      <= div_ff + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_ff <= STC_WAIT_FALL;
    end else if (!ctrl_ff.on || !ctrl_ff.src) begin
      arm_ff <= STC_WAIT_FALL;
    end else begin
      unique case (arm_ff)
        STC_WAIT_FALL: if (ext_fall) arm_ff <= STC_ARMED;
        STC_ARMED:     arm_ff <= STC_ARMED;
      endcase
    end
  end

  assign src_tick = ctrl_ff.src ? (ext_rise && arm_ff == STC_ARMED) : div_tick;

  // ===========================================================================
  // Counter core
  assign wr_cntl  = wr_pend_ff && waddr_ff == STC_OFS_CNTL;
  assign wr_cnth  = wr_pend_ff && waddr_ff == STC_OFS_CNTH;
  assign cnt_wr   = wr_cntl || (wr_cnth && !ctrl_ff.wide);
  assign cnt_wval = wr_cntl ? (ctrl_ff.wide ? {hbuf_ff, wbyte} : {cnt_ff[15:8], wbyte})
                            : {wbyte, cnt_ff[7:0]};
  assign inc      = ctrl_ff.on && src_tick && psc_ff == psc_last(ctrl_ff.prescale);
  // Compare match acts as the period end; software keeps sync on for reliability.
  assign trig     = cmp_mode_ff == STC_MODE_TRIG && cnt_ff == cmp_ff;
  assign ovf_evt  = inc && !cnt_wr && !trig && cnt_ff == STC_CNT_MAX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_ff <= 3'h0;
    end else if (wr_cntl || wr_cnth || !ctrl_ff.on) begin
      psc_ff <= 3'h0;
    end else if (src_tick) begin
      psc_ff <= inc ? 3'h0 : psc_ff + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_wr) begin
      cnt_ff <= cnt_wval;
    end else if (trig) begin
      cnt_ff <= 16'h0000;
    end else if (inc) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // A wide-mode low read latches the high byte so both halves are coherent.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hbuf_ff <= 8'h00;
    end else if (wr_cnth && ctrl_ff.wide) begin
      hbuf_ff <= wbyte;
    end else if (rd_take && haddr[7:0] == STC_OFS_CNTL && ctrl_ff.wide) begin
      hbuf_ff <= cnt_ff[15:8];
    end
  end

  // ===========================================================================
  // Interrupt flags
  // An overflow arriving with a clear of its own bit keeps the bit set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_ff <= STC_FLAG_RST;
    end else begin
      flag_ff[STC_OVF_BIT] <= ovf_evt ||
        (flag_ff[STC_OVF_BIT] && !(wr_pend_ff && waddr_ff == STC_OFS_FLAG
                                   && wbyte[STC_OVF_BIT]));
    end
  end

  assign irq          = |(flag_ff & ien_ff);
  assign irq_priority = prio_ff[STC_OVF_BIT];

  // ===========================================================================
  // Checks
  chk_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> cnt_ff == 16'h0000) else $error("counter did not wrap to zero");
  chk_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_evt |=> flag_ff[STC_OVF_BIT]) else $error("overflow flag not set");
  chk_flag_source: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(flag_ff[STC_OVF_BIT]) |-> $past(ovf_evt))
    else $error("overflow flag set without a wrap");
  chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_ff[STC_OVF_BIT] && !ien_ff[STC_OVF_BIT] |-> !irq)
    else $error("masked overflow raised irq");
  chk_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_ff[STC_OVF_BIT] && ien_ff[STC_OVF_BIT] |-> irq)
    else $error("enabled overflow did not raise irq");
  chk_route_all: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.route_hi && ctrl_ff.route_lo |-> unit_second_pair == 5'h1f)
    else $error("routing wrong for pattern 11");
  chk_route_mid: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.route_hi && !ctrl_ff.route_lo |-> unit_second_pair == 5'h1c)
    else $error("routing wrong for pattern 10");
  chk_route_one: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.route_hi && ctrl_ff.route_lo |-> unit_second_pair == 5'h1e)
    else $error("routing wrong for pattern 01");
  chk_route_none: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.route_hi && !ctrl_ff.route_lo |-> unit_second_pair == 5'h00)
    else $error("routing wrong for pattern 00");
  chk_prescale_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    inc && ctrl_ff.prescale == 2'h3 && !ctrl_ff.src && $stable(ctrl_ff)
    |=> (!inc || ctrl_ff.prescale != 2'h3) [*8])
    else $error("prescale 1:8 counted too soon");
  chk_hold_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.on && !cnt_wr && !trig |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while off");
  chk_pins_input: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_en_ff |-> pin_oe_n == 2'h3 && pin_rd == 2'h0)
    else $error("oscillator pins not released");
  chk_trig_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    trig && !cnt_wr |=> cnt_ff == 16'h0000) else $error("trigger did not clear");
  chk_trig_noflag: assert property (@(posedge hclk) disable iff (!hresetn)
    trig && !flag_ff[STC_OVF_BIT] |=> !flag_ff[STC_OVF_BIT])
    else $error("trigger set overflow flag");
  chk_write_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_wr && trig |=> cnt_ff == $past(cnt_wval)) else $error("write lost to trigger");
  chk_psc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cntl || wr_cnth |=> psc_ff == 3'h0) else $error("prescaler not cleared");
  chk_int_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_ff.src && inc |-> div_tick) else $error("internal count off the cycle tick");
  chk_ext_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.src && arm_ff == STC_WAIT_FALL |-> !inc) else $error("counted before a fall");
  chk_ext_arm: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_ff.on && ctrl_ff.src && ext_fall |=> arm_ff == STC_ARMED)
    else $error("falling edge did not arm the counter");
  chk_wide_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cnth && ctrl_ff.wide && !trig && !inc |=> cnt_ff == $past(cnt_ff))
    else $error("wide high write moved the counter");

endmodule

// ### sim/stc_ext_src.sv
// Purpose: Far-side model of the external count clock for the timer block.
// Assumes: Pin has a pull-up, so it idles high between bursts.
// Notes:   Levels change only just after a rising hclk edge.
`timescale 1ns/1ps
module stc_ext_src (
  input  wire logic hclk,
  output logic      clk_out
);
  // ===========================================================================
  // Burst generator
  initial begin
    clk_out = 1'b1;
  end

  // Each pulse is a falling edge followed by a rising edge, so the first edge
  // seen by the counter is always a falling one and every pulse counts once.
  task automatic send(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      clk_out <= 1'b0;
      repeat (half) @(posedge hclk);
      clk_out <= 1'b1;
      repeat (half - 1) @(posedge hclk);
    end
  endtask
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the sixteen-bit timer/counter three block.
// Assumes: Zero-wait AHB-Lite slave, hready tied back from hreadyout.
// Notes:   Internal counts are checked within a small window, as the divider free-runs.
`timescale 1ns/1ps
module testbench
  import stc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, irq_priority;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, pin_in, pin_out, pin_oe_n;
  logic [2:0]  hsize;
  logic [4:0]  unit_second_pair;
  logic        ext_clk, osc_lane;
  int          n_errors, tests_run, seed, n;
  logic [15:0] rv;

  assign hready = hreadyout;
  assign pin_in = osc_lane ? {ext_clk, 1'b1} : {1'b1, ext_clk};

  stc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .unit_second_pair(unit_second_pair),
    .irq(irq), .irq_priority(irq_priority));
  stc_ext_src ext (.hclk(hclk), .clk_out(ext_clk));

  // ===========================================================================
  // Shared tasks
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rd & m, e);
  endtask

  function automatic logic [4:0] route_exp(input logic [1:0] c);
    return (c == 2'h3) ? 5'h1f : (c == 2'h2) ? 5'h1c : (c == 2'h1) ? 5'h1e : 5'h00;
  endfunction

  task automatic give_verdict();
    $display("counts: %0d compared, %0d wrong", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    give_verdict();
  end

  // ===========================================================================
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; osc_lane = 1'b0; seed = 25600;
    n_errors = 0; tests_run = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(STC_OFS_CTRL, 32'hffffffff, 32'h0);
    rd_chk(STC_OFS_FLAG, 32'hffffffff, 32'h0);
    rd_chk(STC_OFS_PRIO, 32'hffffffff, 32'h1f);
    rd_chk(STC_OFS_CNTL, 32'hffffffff, 32'h0);
    rd_chk(8'h3c, 32'hffffffff, 32'h0);
    check({31'h0, irq_priority}, 32'h1);
    check({30'h0, hresp, hreadyout}, 32'h1);
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      wr(STC_OFS_CTRL, {25'h0, c[1], 2'b00, c[0], 3'b000});
      @(posedge hclk);
      check({27'h0, unit_second_pair}, {27'h0, route_exp(c[1:0])});
    end
    $display("routing done");
    for (int p = 0; p < 4; p++) begin
      wr(STC_OFS_CNTL, 32'h0);
      wr(STC_OFS_CNTH, 32'h0);
      rv = $random(seed);
      wr(STC_OFS_CTRL, {26'h0, p[1:0], 1'b0, rv[0], 2'b01});
      repeat (320) @(posedge hclk);
      wr(STC_OFS_CTRL, 32'h0);
      bus(1'b0, STC_OFS_CNTL, 32'h0);
      n = 320 / (4 << p);
      check({31'h0, (rd[7:0] + 2 >= n) && (rd[7:0] <= n + 2)}, 32'h1);
      repeat (40) @(posedge hclk);
      rd_chk(STC_OFS_CNTL, 32'hff, rd & 32'hff);
    end
    $display("prescale done");
    wr(STC_OFS_CNTH, 32'hff);
    wr(STC_OFS_CNTL, 32'hf0);
    wr(STC_OFS_CTRL, 32'h01);
    repeat (100) @(posedge hclk);
    wr(STC_OFS_CTRL, 32'h00);
    rd_chk(STC_OFS_CNTH, 32'hff, 32'h0);
    rd_chk(STC_OFS_FLAG, 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(STC_OFS_IEN, 32'h2);
    @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(STC_OFS_FLAG, 32'h2);
    rd_chk(STC_OFS_FLAG, 32'h2, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("overflow done");
    // Timer mode, not unsynchronised counting, so the trigger clear is reliable.
    wr(STC_OFS_CMP, 32'h0008);
    wr(STC_OFS_AUX, {24'h0, STC_MODE_TRIG, 4'h0});
    wr(STC_OFS_CNTL, 32'h0);
    wr(STC_OFS_CTRL, 32'h01);
    repeat (200) @(posedge hclk);
    wr(STC_OFS_CTRL, 32'h00);
    bus(1'b0, STC_OFS_CNTL, 32'h0);
    check({31'h0, rd[7:0] <= 8'h08}, 32'h1);
    rd_chk(STC_OFS_CNTH, 32'hff, 32'h0);
    rd_chk(STC_OFS_FLAG, 32'h2, 32'h0);
    // A zero compare value keeps the trigger asserted, so the next write meets it.
    wr(STC_OFS_CMP, 32'h0);
    wr(STC_OFS_CNTL, 32'h0);
    wr(STC_OFS_CNTL, 32'h33);
    rd_chk(STC_OFS_CNTL, 32'hff, 32'h33);
    wr(STC_OFS_AUX, 32'h0);
    wr(STC_OFS_CNTL, 32'h0);
    $display("trigger done");
    for (int k = 0; k < 3; k++) begin
      rv = $random(seed);
      wr(STC_OFS_CTRL, 32'h80);
      wr(STC_OFS_CNTH, {24'h0, rv[15:8]});
      rd_chk(STC_OFS_CNTL, 32'hff, 32'h0);
      rd_chk(STC_OFS_CNTH, 32'hff, 32'h0);
      wr(STC_OFS_CNTH, {24'h0, rv[15:8]});
      wr(STC_OFS_CNTL, {24'h0, rv[7:0]});
      rd_chk(STC_OFS_CNTL, 32'hff, {24'h0, rv[7:0]});
      rd_chk(STC_OFS_CNTH, 32'hff, {24'h0, rv[15:8]});
      wr(STC_OFS_CTRL, 32'h00);
      wr(STC_OFS_CNTL, 32'h0);
      rd_chk(STC_OFS_CNTH, 32'hff, {24'h0, rv[15:8]});
      wr(STC_OFS_CNTH, 32'h0);
    end
    $display("access width done");
    wr(STC_OFS_PORT, 32'h08);
    @(posedge hclk);
    check({30'h0, pin_oe_n}, 32'h0);
    check({30'h0, pin_out}, 32'h2);
    for (int s = 0; s < 2; s++) begin
      n = 3 + ($random(seed) & 7);
      osc_lane <= s[0];
      wr(STC_OFS_AUX, {31'h0, s[0]});
      @(posedge hclk);
      check({30'h0, pin_oe_n}, s ? 32'h3 : 32'h0);
      if (s == 1) rd_chk(STC_OFS_PORT, 32'h30, 32'h0);
      wr(STC_OFS_CNTL, 32'h0);
      wr(STC_OFS_CTRL, {29'h0, s[0], 2'b11});
      ext.send(n, 4);
      repeat (8) @(posedge hclk);
      wr(STC_OFS_CTRL, 32'h0);
      rd_chk(STC_OFS_CNTL, 32'hff, n);
    end
    $display("external clock done");
    give_verdict();
  end
endmodule
